// file: rtl/hbm_dma_map.vh
// Constants for the host bus master DMA interface.
// Summary of operation
// - Raise hold request to ask for bus.
// - Hold acknowledge drives bus-owned low.
// - Drive data direction once bus is owned.
// - First cycle: 24-bit address, two latch strobes.
// - After address, read/write strobe then data enable.
// - Ready low inserts wait states until high.
// - Upper byte reissued on low-byte carry and after each re-request.
// - Burst release gives up bus, owned high.
// - Remaining work re-requests bus at the next phase tick.
// - Release: drop request, float pins, drop owned.
// - Interrupt request output driven high.
// - Host clears interrupt writing zero bit 7.
// - Host reset input resets the device.
// - Strap low selects 16-bit data path.
// - Address and data share multiplexed lines.
// - Direction low on register writes, DMA reads.
// - Owned low: device drives bus controls.
// - Chip select and two select lines pick registers.
`ifndef HBM_DMA_MAP_VH
`define HBM_DMA_MAP_VH

`define HBM_CLK_MHZ 200
`define HBM_PHASE_NS 20
`define HBM_PHASE_CYCLES ((`HBM_PHASE_NS * `HBM_CLK_MHZ) / 1000)
`define HBM_FIFO_WIDTH 16
`define HBM_FIFO_DEPTH 16
`define HBM_FIFO_AW 4
`define HBM_ADDR_W 24
`define HBM_CNT_W 16
`define HBM_REG_INT 2'h0
`define HBM_INT_BIT 7
`define HBM_BUSY_BIT 0
`define HBM_SYNC_W 10
`define HBM_PIN_IDLE 10'h033

`endif

// file: rtl/hbm_fifo.v
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module hbm_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] fill_q;
    wire push;
    wire pop;

    assign in_ready = (fill_q != DEPTH);
    assign out_valid = (fill_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            fill_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                fill_q <= fill_q + 1'b1;
            end else if (pop && !push) begin
                fill_q <= fill_q - 1'b1;
            end
        end
    end
endmodule

// file: rtl/hbm_dma_if.v
// Host bus master DMA engine with direct register access port.
`timescale 1ns/1ps
`include "hbm_dma_map.vh"
module hbm_dma_if (
    input wire ref_clk,
    input wire rst,
    input wire dma_start,
    input wire [23:0] dma_addr,
    input wire [15:0] dma_count,
    input wire dma_write,
    output wire dma_busy,
    output reg dma_done,
    input wire [15:0] wr_data,
    input wire wr_valid,
    output wire wr_ready,
    output reg [15:0] rd_data,
    output reg rd_valid,
    input wire int_set,
    output reg dio_wr,
    output reg [1:0] dio_index,
    output reg [15:0] dio_wdata,
    input wire [15:0] dio_rdata,
    output reg bus_hold_request,
    input wire bus_hold_acknowledge,
    output reg bus_owned_n,
    output reg data_direction,
    output reg extended_address_latch_strobe,
    output reg address_latch_strobe,
    output reg read_strobe,
    output reg write_strobe,
    output reg data_bus_enable,
    output wire ctl_oe_n,
    input wire channel_ready,
    input wire burst_release,
    output reg host_interrupt_request,
    input wire host_reset_input,
    input wire bus_mode_n,
    input wire [15:0] muxed_address_data_lines_in,
    output reg [15:0] muxed_address_data_lines_out,
    output reg muxed_address_data_lines_oe_n,
    input wire chip_select_n,
    input wire register_select_0,
    input wire register_select_1,
    input wire host_read_n,
    input wire host_write_n
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_REQ = 7'h02;
    localparam [6:0] S_XADR = 7'h04;
    localparam [6:0] S_ADR = 7'h08;
    localparam [6:0] S_STRB = 7'h10;
    localparam [6:0] S_WAIT = 7'h20;
    localparam [6:0] S_REL = 7'h40;
    localparam integer PHASE_LAST_I = `HBM_PHASE_CYCLES - 1;
    localparam [7:0] PHASE_LAST = PHASE_LAST_I[7:0];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Every pin from the host bus is asynchronous to ref_clk.
    reg [`HBM_SYNC_W-1:0] pin_meta_q;
    reg [`HBM_SYNC_W-1:0] pin_sync_q;
    reg [15:0] ad_meta_q;
    reg [15:0] ad_sync_q;
    wire [`HBM_SYNC_W-1:0] pin_raw;
    wire hrst_s;
    wire hlda_s;
    wire brls_s;
    wire rdy_s;
    wire cs_n_s;
    wire [1:0] rs_s;
    wire rd_n_s;
    wire wr_n_s;
    wire mode16_s;
    wire irst;

    assign pin_raw = {bus_mode_n, host_reset_input, bus_hold_acknowledge, burst_release,
                      channel_ready, chip_select_n, register_select_1, register_select_0,
                      host_read_n, host_write_n};

    always @(posedge ref_clk) begin
        if (rst) begin
            // Idle pin levels, so no false host reset or select follows reset.
            pin_meta_q <= `HBM_PIN_IDLE;
            pin_sync_q <= `HBM_PIN_IDLE;
            ad_meta_q <= 16'h0000;
            ad_sync_q <= 16'h0000;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            ad_meta_q <= muxed_address_data_lines_in;
            ad_sync_q <= ad_meta_q;
        end
    end

    assign mode16_s = !pin_sync_q[9];
    assign hrst_s = pin_sync_q[8];
    assign hlda_s = pin_sync_q[7];
    assign brls_s = pin_sync_q[6];
    assign rdy_s = pin_sync_q[5];
    assign cs_n_s = pin_sync_q[4];
    assign rs_s = pin_sync_q[3:2];
    assign rd_n_s = pin_sync_q[1];
    assign wr_n_s = pin_sync_q[0];
    assign irst = rst || hrst_s;

    // ------------------------------------------------------------
    // Bus phase divider
    // ------------------------------------------------------------
    // Each bus phase lasts one tick so the extended latch sees a wide strobe; the address latch strobe is one clock.
    reg [7:0] div_q;
    wire tick;

    assign tick = (div_q == PHASE_LAST);

    always @(posedge ref_clk) begin
        if (irst) begin
            div_q <= 8'h00;
        end else if (tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Write data buffer
    // ------------------------------------------------------------
    wire [15:0] fifo_data;
    wire fifo_valid;
    reg fifo_pop;

    hbm_fifo #(
        .WIDTH(`HBM_FIFO_WIDTH),
        .DEPTH(`HBM_FIFO_DEPTH),
        .AW(`HBM_FIFO_AW)
    ) u_fifo (
        .clk(ref_clk),
        .rst(irst),
        .in_data(wr_data),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // ------------------------------------------------------------
    // DMA sequencer
    // ------------------------------------------------------------
    reg [6:0] state_q;
    reg [23:0] addr_q;
    reg [15:0] count_q;
    reg write_q;
    reg xal_need_q;
    reg [15:0] wdata_q;
    wire [23:0] addr_next;
    wire low_carry;

    // A 16-bit path moves two bytes per cycle, a byte path one.
    assign addr_next = addr_q + (mode16_s ? 24'h000002 : 24'h000001);
    assign low_carry = (addr_next[15:8] != addr_q[15:8]);
    assign dma_busy = (state_q != S_IDLE);

    always @(posedge ref_clk) begin
        if (irst) begin
            state_q <= S_IDLE;
            addr_q <= 24'h000000;
            count_q <= 16'h0000;
            write_q <= 1'b0;
            xal_need_q <= 1'b0;
            wdata_q <= 16'h0000;
            bus_hold_request <= 1'b0;
            bus_owned_n <= 1'b1;
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
            dma_done <= 1'b0;
            fifo_pop <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            dma_done <= 1'b0;
            fifo_pop <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (dma_start && dma_count != 16'h0000) begin
                        addr_q <= dma_addr;
                        count_q <= dma_count;
                        write_q <= dma_write;
                        xal_need_q <= 1'b1;
                        bus_hold_request <= 1'b1;
                        state_q <= S_REQ;
                    end
                end
                S_REQ: begin
                    bus_hold_request <= 1'b1;
                    if (tick && hlda_s) begin
                        bus_owned_n <= 1'b0;
                        state_q <= xal_need_q ? S_XADR : S_ADR;
                    end
                end
                S_XADR: begin
                    if (tick) begin
                        xal_need_q <= 1'b0;
                        state_q <= S_ADR;
                    end
                end
                S_ADR: begin
                    if (tick) begin
                        if (brls_s) begin
                            state_q <= S_REL;
                        end else if (!write_q || fifo_valid) begin
                            // A write waits here while the buffer is empty.
                            if (write_q) begin
                                wdata_q <= fifo_data;
                                fifo_pop <= 1'b1;
                            end
                            state_q <= S_STRB;
                        end
                    end
                end
                S_STRB: begin
                    if (tick) begin
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (tick && rdy_s) begin
                        if (!write_q) begin
                            rd_data <= ad_sync_q;
                            rd_valid <= 1'b1;
                        end
                        count_q <= count_q - 16'h0001;
                        addr_q <= addr_next;
                        xal_need_q <= low_carry;
                        if (count_q == 16'h0001 || brls_s) begin
                            state_q <= S_REL;
                        end else begin
                            state_q <= low_carry ? S_XADR : S_ADR;
                        end
                    end
                end
                S_REL: begin
                    bus_hold_request <= 1'b0;
                    bus_owned_n <= 1'b1;
                    if (tick) begin
                        if (count_q != 16'h0000) begin
                            // The address latches lose their byte on release.
                            xal_need_q <= 1'b1;
                            bus_hold_request <= 1'b1;
                            state_q <= S_REQ;
                        end else begin
                            dma_done <= 1'b1;
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: begin
                    bus_hold_request <= 1'b0;
                    bus_owned_n <= 1'b1;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Direct register access
    // ------------------------------------------------------------
    reg wr_n_prev_q;
    wire dio_sel;
    wire dio_rd;
    wire dio_wr_edge;

    assign dio_sel = !cs_n_s && bus_owned_n;
    assign dio_rd = dio_sel && !rd_n_s;
    assign dio_wr_edge = dio_sel && !wr_n_s && wr_n_prev_q;

    always @(posedge ref_clk) begin
        if (irst) begin
            wr_n_prev_q <= 1'b1;
            dio_wr <= 1'b0;
            dio_index <= 2'h0;
            dio_wdata <= 16'h0000;
            host_interrupt_request <= 1'b0;
        end else begin
            wr_n_prev_q <= wr_n_s;
            dio_wr <= dio_wr_edge;
            if (dio_wr_edge) begin
                dio_index <= rs_s;
                dio_wdata <= ad_sync_q;
            end
            // A new event in the clearing cycle keeps the request up.
            if (int_set) begin
                host_interrupt_request <= 1'b1;
            end else if (dio_wr_edge && rs_s == `HBM_REG_INT
                         && !ad_sync_q[`HBM_INT_BIT]) begin
                host_interrupt_request <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Control pins float whenever the bus belongs to the host.
    assign ctl_oe_n = bus_owned_n;

    always @(posedge ref_clk) begin
        if (irst) begin
            muxed_address_data_lines_out <= 16'h0000;
            muxed_address_data_lines_oe_n <= 1'b1;
            extended_address_latch_strobe <= 1'b0;
            address_latch_strobe <= 1'b0;
            read_strobe <= 1'b0;
            write_strobe <= 1'b0;
            data_bus_enable <= 1'b0;
            data_direction <= 1'b0;
        end else begin
            extended_address_latch_strobe <= (state_q == S_XADR);
            address_latch_strobe <= (state_q == S_ADR) && tick
                                    && (!write_q || fifo_valid) && !brls_s;
            read_strobe <= !write_q && (state_q == S_STRB || state_q == S_WAIT);
            write_strobe <= write_q && (state_q == S_STRB || state_q == S_WAIT);
            if (!bus_owned_n) begin
                data_direction <= write_q;
                data_bus_enable <= (state_q == S_WAIT);
            end else begin
                data_direction <= dio_rd;
                data_bus_enable <= dio_sel && (!rd_n_s || !wr_n_s);
            end
            // One set of lines carries address then data.
            case (state_q)
                S_XADR: begin
                    muxed_address_data_lines_out <= {8'h00, addr_q[23:16]};
                    muxed_address_data_lines_oe_n <= 1'b0;
                end
                S_ADR: begin
                    muxed_address_data_lines_out <= addr_q[15:0];
                    muxed_address_data_lines_oe_n <= 1'b0;
                end
                S_STRB, S_WAIT: begin
                    muxed_address_data_lines_out <= wdata_q;
                    muxed_address_data_lines_oe_n <= !write_q;
                end
                default: begin
                    if (dio_rd) begin
                        if (rs_s == `HBM_REG_INT) begin
                            muxed_address_data_lines_out <=
                                {8'h00, host_interrupt_request, 6'h00, dma_busy};
                        end else begin
                            muxed_address_data_lines_out <= dio_rdata;
                        end
                    end
                    muxed_address_data_lines_oe_n <= !dio_rd;
                end
            endcase
        end
    end
endmodule

// file: verification/hbm_dma_chk.sv
// Concurrent checks on the pins of the host bus master DMA engine.
`timescale 1ns/1ps
module hbm_dma_chk (
    input wire ref_clk,
    input wire rst,
    input wire int_set,
    input wire rd_valid,
    input wire dma_busy,
    input wire bus_hold_request,
    input wire bus_hold_acknowledge,
    input wire bus_owned_n,
    input wire data_direction,
    input wire extended_address_latch_strobe,
    input wire address_latch_strobe,
    input wire read_strobe,
    input wire write_strobe,
    input wire data_bus_enable,
    input wire ctl_oe_n,
    input wire channel_ready,
    input wire host_interrupt_request,
    input wire host_reset_input
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Bus tenure, strobes and interrupt
    // ----------------------------------------
    a_own_after_ack: assert property ($fell(bus_owned_n) |->
        bus_hold_request && $past(bus_hold_acknowledge, 3)) else $error("owned without grant");
    a_strobe_owned: assert property ((read_strobe || write_strobe ||
        address_latch_strobe || extended_address_latch_strobe) |-> !bus_owned_n)
        else $error("strobe while bus not owned");
    a_rw_excl: assert property (!(read_strobe && write_strobe))
        else $error("read and write strobe together");
    a_dben_strobe: assert property ((data_bus_enable && !bus_owned_n) |->
        (read_strobe || write_strobe)) else $error("data enable outside a strobe");
    a_dir_match: assert property ((read_strobe || write_strobe) |->
        data_direction == write_strobe) else $error("direction wrong for transfer");
    a_wait_ready: assert property ((!bus_owned_n && !channel_ready) [*6] |->
        !rd_valid) else $error("cycle ended while not ready");
    a_release_drop: assert property ($rose(bus_owned_n) |->
        ##[0:1] !bus_hold_request) else $error("request held after release");
    a_ctl_follow: assert property (ctl_oe_n == bus_owned_n)
        else $error("control enable differs from ownership");
    a_rerequest: assert property ($rose(bus_owned_n) |->
        ##[1:12] (bus_hold_request || !dma_busy)) else $error("no new request");
    a_int_set: assert property (int_set |=> host_interrupt_request)
        else $error("interrupt not raised");
    a_xal_first: assert property ($fell(bus_owned_n) |->
        ##[0:4] extended_address_latch_strobe) else $error("no upper address strobe");
    a_host_reset: assert property (host_reset_input [*5] |->
        bus_owned_n && !bus_hold_request && !host_interrupt_request)
        else $error("host reset not applied");
    c_tenure: cover property ($fell(bus_owned_n));
    c_forced: cover property ($rose(bus_owned_n) && dma_busy);
    c_wait: cover property (read_strobe && !channel_ready);
    c_read: cover property (rd_valid);
endmodule

bind hbm_dma_if hbm_dma_chk hbm_dma_chk_i (.*);

// file: verification/hbm_host_model.sv
// Behavioural model of the host bus, its arbiter and the burst limiter.
`timescale 1ns/1ps
module hbm_host_model (
    input wire ref_clk,
    input wire rst,
    input wire slow,
    input wire host_drv,
    input wire [15:0] host_data,
    input wire bus_hold_request,
    output wire bus_hold_acknowledge,
    input wire bus_owned_n,
    input wire extended_address_latch_strobe,
    input wire address_latch_strobe,
    input wire read_strobe,
    input wire write_strobe,
    input wire [15:0] muxed_address_data_lines_out,
    output wire [15:0] muxed_address_data_lines_in,
    output wire channel_ready,
    output wire burst_release,
    output logic [31:0] ale_cnt,
    output logic [31:0] own_cnt,
    output logic [31:0] xal_cnt
);
    logic [2:0] hq;
    logic [3:0] bc, wcnt;
    logic [15:0] alo, wlast, prev;
    logic ale_q, xal_q, own_q, stb_q, wr_q;
    logic [31:0] wq[$];
    wire stb = read_strobe | write_strobe;
    wire ale_rise = address_latch_strobe & ~ale_q;
    // ----------------------------------------
    // Host side responses
    // ----------------------------------------
    // A slow arbiter grants late, which stresses the synchroniser path.
    assign bus_hold_acknowledge = slow ? hq[2] : hq[0];
    assign burst_release = bc == 4'hf;
    assign channel_ready = wcnt == 4'h0;
    // Idle lines show the inverse of their last level, so no stale value passes.
    assign muxed_address_data_lines_in = read_strobe ? alo ^ 16'ha5c3 :
        host_drv ? host_data : ~prev;
    always @(posedge ref_clk) begin
        hq <= {hq[1:0], bus_hold_request};
        prev <= muxed_address_data_lines_in;
        ale_q <= address_latch_strobe;
        xal_q <= extended_address_latch_strobe;
        own_q <= bus_owned_n;
        stb_q <= stb;
        wr_q <= write_strobe;
        if (address_latch_strobe) alo <= muxed_address_data_lines_out;
        if (write_strobe) wlast <= muxed_address_data_lines_out;
        if (wr_q && !write_strobe) wq.push_back({alo, wlast});
        if (bus_owned_n) bc <= 4'h0;
        else if (ale_rise && bc != 4'hf) bc <= bc + 4'h1;
        if (slow && stb && !stb_q) wcnt <= 4'h8;
        else if (wcnt != 4'h0) wcnt <= wcnt - 4'h1;
        if (ale_rise) ale_cnt <= ale_cnt + 32'h1;
        if (extended_address_latch_strobe && !xal_q) xal_cnt <= xal_cnt + 32'h1;
        if (!bus_owned_n && own_q) own_cnt <= own_cnt + 32'h1;
        if (rst) begin
            hq <= 3'h0;
            bc <= 4'h0;
            wcnt <= 4'h0;
            prev <= 16'h0;
            ale_cnt <= 32'h0;
            own_cnt <= 32'h0;
            xal_cnt <= 32'h0;
        end
    end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the host bus master DMA engine.
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'h0, rst = 1'h1, dma_start = 1'h0, dma_write = 1'h0, wr_valid = 1'h0;
    logic int_set = 1'h0, host_reset_input = 1'h0, bus_mode_n = 1'h0, chip_select_n = 1'h1;
    logic register_select_0 = 1'h0, register_select_1 = 1'h0, host_read_n = 1'h1;
    logic host_write_n = 1'h1, slow = 1'h0, host_drv = 1'h0, dirv;
    logic [23:0] dma_addr = 24'h0, base, ra;
    logic [15:0] dma_count = 16'h0, wr_data = 16'h0, dio_rdata = 16'h0, host_data = 16'h0, q, wd;
    logic [15:0] wexp[$];
    logic [1:0] wi;
    wire dma_busy, dma_done, wr_ready, rd_valid, dio_wr, bus_hold_request, bus_hold_acknowledge;
    wire bus_owned_n, data_direction, extended_address_latch_strobe, address_latch_strobe;
    wire read_strobe, write_strobe, data_bus_enable, ctl_oe_n, channel_ready, burst_release;
    wire host_interrupt_request, muxed_address_data_lines_oe_n;
    wire [15:0] rd_data, dio_wdata, muxed_address_data_lines_in, muxed_address_data_lines_out;
    wire [1:0] dio_index;
    wire [31:0] ale_cnt, own_cnt, xal_cnt;
    int mismatches = 0, num_checks = 0, cyc = 0, rdi = 0, wseen = 0, stp = 2, rn;

    hbm_dma_if hbm_dma_if_i (.*);
    hbm_host_model hbm_host_model_i (.*);

    always #2.5 ref_clk = ~ref_clk;

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            test_done;
        end
    end

    function automatic logic [15:0] alow(input int i);
        logic [23:0] a;
        a = base + 24'(i * stp);
        return a[15:0];
    endfunction

    always @(negedge ref_clk) begin
        if (rd_valid === 1'h1) begin
            chk(rd_data, alow(rdi) ^ 16'ha5c3);
            rdi++;
        end
        if (dio_wr === 1'h1) begin
            wseen++;
            wi = dio_index;
            wd = dio_wdata;
        end
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task hreg(input logic w, input logic [1:0] idx, input logic [15:0] d);
        @(negedge ref_clk);
        chip_select_n = 1'h0;
        register_select_0 = idx[0];
        register_select_1 = idx[1];
        host_data = d;
        host_drv = w;
        @(negedge ref_clk);
        if (w) host_write_n = 1'h0;
        else host_read_n = 1'h0;
        repeat (6) @(negedge ref_clk);
        q = muxed_address_data_lines_out;
        dirv = data_direction;
        chk(data_bus_enable, 1);
        if (!w) chk(muxed_address_data_lines_oe_n, 0);
        host_write_n = 1'h1;
        host_read_n = 1'h1;
        @(negedge ref_clk);
        chip_select_n = 1'h1;
        host_drv = 1'h0;
        repeat (4) @(negedge ref_clk);
    endtask

    task push(input logic [15:0] d);
        @(negedge ref_clk);
        wr_data = d;
        wr_valid = 1'h1;
        while (wr_ready !== 1'h1) @(negedge ref_clk);
        @(negedge ref_clk);
        wr_valid = 1'h0;
    endtask

    task start(input logic [23:0] a, input int n, input logic w);
        base = a;
        rdi = 0;
        stp = bus_mode_n ? 1 : 2;
        @(negedge ref_clk);
        dma_addr = a;
        dma_count = 16'(n);
        dma_write = w;
        dma_start = 1'h1;
        @(negedge ref_clk);
        dma_start = 1'h0;
    endtask

    // The carry count only holds inside one tenure, so it is checked up to 15 cycles.
    task run(input logic [23:0] a, input int n, input logic w);
        int a0, o0, x0, k, c;
        wexp.delete();
        hbm_host_model_i.wq.delete();
        for (k = 0; k < n && w; k++) begin
            wexp.push_back(16'($urandom));
            push(wexp[k]);
        end
        if (w && n == 16) chk(wr_ready, 0);
        a0 = ale_cnt;
        o0 = own_cnt;
        x0 = xal_cnt;
        start(a, n, w);
        for (k = 0; k < 8000 && dma_done !== 1'h1; k++) @(negedge ref_clk);
        chk(dma_done, 1);
        chk(ale_cnt - a0, n);
        chk(own_cnt - o0, (n + 14) / 15);
        if (!w) chk(rdi, n);
        if (w) chk(hbm_host_model_i.wq.size(), n);
        for (k = 0; k < n && w; k++) chk(hbm_host_model_i.wq[k], {alow(k), wexp[k]});
        c = 1;
        for (k = 1; k < n; k++) c += (alow(k) >> 8) != (alow(k - 1) >> 8);
        if (n <= 15) chk(xal_cnt - x0, c);
        if (w) chk(wr_ready, 1);
        $display("test dma %h count %0d write %0d done", a, n, w);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h78fd));
        repeat (3) @(negedge ref_clk);
        rst = 1'h0;
        hreg(1, 2'h3, 16'h5a3c);
        chk(wseen, 1);
        chk(wi, 3);
        chk(wd, 16'h5a3c);
        chk(dirv, 0);
        dio_rdata = 16'hc3e1;
        hreg(0, 2'h2, 16'h0);
        chk(q, 16'hc3e1);
        chk(dirv, 1);
        @(negedge ref_clk);
        int_set = 1'h1;
        @(negedge ref_clk);
        int_set = 1'h0;
        repeat (2) @(negedge ref_clk);
        chk(host_interrupt_request, 1);
        hreg(0, 2'h0, 16'h0);
        chk(q, 16'h0080);
        hreg(1, 2'h0, 16'h0080);
        chk(host_interrupt_request, 1);
        hreg(1, 2'h0, 16'h0);
        chk(host_interrupt_request, 0);
        $display("test register port done");
        run(24'h1234fc, 4, 0);
        slow = 1'h1;
        run(24'h00fff8, 8, 1);
        bus_mode_n = 1'h1;
        run(24'h00a0fe, 5, 0);
        bus_mode_n = 1'h0;
        run(24'h0200f0, 31, 0);
        run(24'h040010, 16, 1);
        repeat (8) begin
            bus_mode_n = 1'($urandom);
            slow = 1'($urandom);
            ra = 24'($urandom);
            ra[0] = ra[0] & bus_mode_n;
            rn = 1 + $urandom % 16;
            run(ra, rn, 1'($urandom));
        end
        start(24'h000100, 30, 0);
        int_set = 1'h1;
        repeat (80) @(negedge ref_clk);
        int_set = 1'h0;
        host_reset_input = 1'h1;
        repeat (8) @(negedge ref_clk);
        chk(bus_owned_n, 1);
        chk(bus_hold_request, 0);
        chk(dma_busy, 0);
        chk(host_interrupt_request, 0);
        host_reset_input = 1'h0;
        repeat (10) @(negedge ref_clk);
        run(24'h000200, 3, 0);
        $display("test host reset done");
        test_done;
    end
endmodule
